// >>> hw/lvd_params.svh
// constants for the supply supervisor control block
`ifndef LVD_PARAMS_SVH
`define LVD_PARAMS_SVH
// register byte offsets
`define LVD_CTRL_OFS       12'h000
`define LVD_STAT_OFS       12'h004
`define LVD_IRQ_STAT_OFS   12'h008
`define LVD_IRQ_MASK_OFS   12'h00c
// control field positions
`define LVD_SUP_EN_BIT     7
`define LVD_REF_EN_BIT     6
`define LVD_SRC_SEL_BIT    5
`define LVD_FIXED_ONE_BIT  4
`define LVD_THR_SEL_BIT    3
`define LVD_RST_EN_BIT     2
`define LVD_FALL_EN_BIT    1
`define LVD_RISE_EN_BIT    0
// status field positions
`define LVD_FALL_FLAG_BIT  1
`define LVD_RISE_FLAG_BIT  0
// reset values
`define LVD_CTRL_RESET     8'hf4
`define LVD_CTRL_KEEP_MASK 8'hec
`define LVD_STAT_RESERVED  8'hfc
// reset hold time after supply recovery
`define LVD_HOLD_US        100
`define LVD_CLK_MHZ        200
`define LVD_HOLD_CYCLES    (`LVD_HOLD_US * `LVD_CLK_MHZ)
`endif

// >>> hw/lvd_pkg.sv
// types for the supply supervisor control block
`default_nettype none
package lvd_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RST  = 2'b01,
    ST_HOLD = 2'b11
  } rst_state_t;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic        fall_flag;
    logic        rise_flag;
    logic        fall_read;
    logic        rise_read;
    logic        fall_armed;
    logic        rise_seen;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    rst_state_t  rst_state;
    logic [31:0] hold_cnt;
    logic [31:0] prdata;
  } lvd_state_t;
endpackage
`default_nettype wire

// >>> hw/supply_monitor.sv
// supply supervisor control: register file, events, reset sequencer
// What this block does
// - bit 7 zero puts the whole supervisor in standby, one runs it.
// - bit 6 zero puts the reference generator in standby, one runs it.
// - bit 5 picks external (0) or internal (1) compared voltage.
// - bit 4 always reads one and writes to it are ignored.
// - bit 3 picks the low (0) or high (1) reset threshold.
// - bit 2 one lets a supply drop assert the reset, zero blocks it.
// - the fall interrupt request passes only while bit 1 is one.
// - the rise interrupt request passes only while bit 0 is one.
// - supply drop and supply recovery give separate events.
// - after recovery the reset is held a fixed time, then released.
// - kept control fields survive a supervisor reset.
// - flags set on events; software clears one by writing 0 after 1.
`timescale 1ns/1ps
`default_nettype none
`include "lvd_params.svh"
module supply_monitor #(
  parameter int unsigned HOLD_CYCLES = `LVD_HOLD_CYCLES
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // comparator inputs from the analog side, asynchronous
  input  wire logic        BELOW_RESET_LVL,
  input  wire logic        BELOW_FALL_LVL,
  input  wire logic        ABOVE_RISE_LVL,
  // analog control outputs
  output logic             SUPERVISOR_ON,
  output logic             REFERENCE_ON,
  output logic             COMPARE_INTERNAL,
  output logic             THRESHOLD_HIGH,
  // supervisor reset and interrupts
  output logic             UNDERVOLT_RESET,
  output logic             FALL_IRQ,
  output logic             RISE_IRQ,
  output logic             IRQ
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [2:0] sync1;
  logic [2:0] sync2;
  // first stage feeds only the second
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {BELOW_RESET_LVL, BELOW_FALL_LVL, ABOVE_RISE_LVL};
      sync2 <= sync1;
    end
  end
  logic below_rst;
  logic below_fall;
  logic above_rise;
  assign below_rst  = sync2[2];
  assign below_fall = sync2[1];
  assign above_rise = sync2[0];

  // ************************************************************
  // state and bus decode
  // ************************************************************
  lvd_pkg::lvd_state_t st;
  lvd_pkg::lvd_state_t next_st;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       mapped;
  logic       sup_on;
  logic       fall_evt;
  logic       rise_evt;
  logic       drop;
  logic       setup_rd;
  logic       recover;
  logic [7:0] stat_rd;

  assign acc = PSEL && PENABLE;
  assign wr  = acc && PWRITE;
  assign rd  = acc && !PWRITE;
  assign setup_rd = PSEL && !PENABLE && !PWRITE;
  assign mapped = (PADDR == `LVD_CTRL_OFS) || (PADDR == `LVD_STAT_OFS) ||
                  (PADDR == `LVD_IRQ_STAT_OFS) ||
                  (PADDR == `LVD_IRQ_MASK_OFS);
  assign sup_on = st.ctrl[`LVD_SUP_EN_BIT];
  assign stat_rd = `LVD_STAT_RESERVED |
                   {6'h00, st.fall_flag, st.rise_flag};

  // events only while the supervisor runs; recovery re-arms the fall
  // event even when no rise event was asked for, so each drop is seen
  assign recover  = st.fall_armed && above_rise && !below_fall;
  assign fall_evt = sup_on && below_fall && !st.fall_armed;
  assign rise_evt = sup_on && recover && st.rise_seen;
  assign drop = sup_on && st.ctrl[`LVD_RST_EN_BIT] && below_rst;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_st = st;
    next_st.prdata = 32'h0;
    // control register, bit 4 pinned high
    if (wr && PADDR == `LVD_CTRL_OFS) begin
      next_st.ctrl = PWDATA[7:0];
      next_st.ctrl[`LVD_FIXED_ONE_BIT] = 1'b1;
    end
    // status: a flag seen as one by a read arms its clear
    if (rd && PADDR == `LVD_STAT_OFS) begin
      if (st.prdata[`LVD_FALL_FLAG_BIT])
        next_st.fall_read = 1'b1;
      if (st.prdata[`LVD_RISE_FLAG_BIT])
        next_st.rise_read = 1'b1;
    end
    // status: write 0 clears only a flag already read as one
    if (wr && PADDR == `LVD_STAT_OFS) begin
      if (!PWDATA[`LVD_FALL_FLAG_BIT] && st.fall_read) begin
        next_st.fall_flag = 1'b0;
        next_st.fall_read = 1'b0;
      end
      if (!PWDATA[`LVD_RISE_FLAG_BIT] && st.rise_read) begin
        next_st.rise_flag = 1'b0;
        next_st.rise_read = 1'b0;
      end
    end
    if (wr && PADDR == `LVD_IRQ_MASK_OFS)
      next_st.irq_mask = PWDATA[1:0];
    // clear only what the read reported, so an event that lands
    // between setup and access is not lost
    if (rd && PADDR == `LVD_IRQ_STAT_OFS)
      next_st.irq_stat = st.irq_stat & ~st.prdata[1:0];
    // fall arming and rise tracking
    if (fall_evt) begin
      next_st.fall_armed = 1'b1;
      next_st.rise_seen  = st.ctrl[`LVD_RISE_EN_BIT];
    end
    if (recover || !sup_on)
      next_st.fall_armed = 1'b0;
    if (below_rst)
      next_st.rise_seen = 1'b0;
    // sets win over the software clears above; the supervisor reset below still clears the flags
    if (fall_evt) begin
      next_st.fall_flag = 1'b1;
      next_st.irq_stat[1] = 1'b1;
    end
    if (rise_evt) begin
      next_st.rise_flag = 1'b1;
      next_st.irq_stat[0] = 1'b1;
    end
    // reset sequencer: hold fixed time after recovery
    unique case (st.rst_state)
      lvd_pkg::ST_IDLE: begin
        if (drop)
          next_st.rst_state = lvd_pkg::ST_RST;
      end
      lvd_pkg::ST_RST: begin
        next_st.hold_cnt = 32'h0;
        if (!below_rst)
          next_st.rst_state = lvd_pkg::ST_HOLD;
      end
      lvd_pkg::ST_HOLD: begin
        if (below_rst)
          next_st.rst_state = lvd_pkg::ST_RST;
        else if (st.hold_cnt >= HOLD_CYCLES - 1)
          next_st.rst_state = lvd_pkg::ST_IDLE;
        else
          next_st.hold_cnt = st.hold_cnt + 32'h1;
      end
      default: next_st.rst_state = lvd_pkg::ST_IDLE;
    endcase
    // supervisor reset: keep marked control bits, clear flags
    if (st.rst_state != lvd_pkg::ST_IDLE) begin
      next_st.ctrl = (st.ctrl & `LVD_CTRL_KEEP_MASK) |
                     (`LVD_CTRL_RESET & ~`LVD_CTRL_KEEP_MASK);
      next_st.fall_flag = 1'b0;
      next_st.rise_flag = 1'b0;
      next_st.fall_read = 1'b0;
      next_st.rise_read = 1'b0;
    end
    // read data, captured in the setup cycle so the access cycle
    // serves it from a flop with no wait state
    if (setup_rd) begin
      if (PADDR == `LVD_CTRL_OFS)
        next_st.prdata = {24'h0, st.ctrl};
      else if (PADDR == `LVD_STAT_OFS)
        next_st.prdata = {24'h0, stat_rd};
      else if (PADDR == `LVD_IRQ_STAT_OFS)
        next_st.prdata = {30'h0, st.irq_stat};
      else if (PADDR == `LVD_IRQ_MASK_OFS)
        next_st.prdata = {30'h0, st.irq_mask};
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  // srst stands for power-on or watchdog reset: full init
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st           <= '0;
      st.ctrl      <= `LVD_CTRL_RESET;
      st.rst_state <= lvd_pkg::ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // read data comes from the flop loaded in the setup cycle
  assign PRDATA  = rd ? st.prdata : 32'h0;
  assign PREADY  = 1'b1;
  assign PSLVERR = acc && !mapped;

  assign SUPERVISOR_ON    = sup_on;
  assign REFERENCE_ON     = st.ctrl[`LVD_REF_EN_BIT];
  assign COMPARE_INTERNAL = st.ctrl[`LVD_SRC_SEL_BIT];
  assign THRESHOLD_HIGH   = st.ctrl[`LVD_THR_SEL_BIT];
  assign UNDERVOLT_RESET  = st.rst_state != lvd_pkg::ST_IDLE;
  assign FALL_IRQ = st.fall_flag && st.ctrl[`LVD_FALL_EN_BIT];
  assign RISE_IRQ = st.rise_flag && st.ctrl[`LVD_RISE_EN_BIT];
  // summary line: sticky status, unmasked, and its request enabled
  assign IRQ = |(st.irq_stat & st.irq_mask &
                 {st.ctrl[`LVD_FALL_EN_BIT], st.ctrl[`LVD_RISE_EN_BIT]});

  // ************************************************************
  // assertions
  // ************************************************************
  a_fixed_one: assert property (@(posedge CLK) disable iff (SRST)
    st.ctrl[`LVD_FIXED_ONE_BIT])
    else $error("control bit 4 not one");
  a_fall_gate: assert property (@(posedge CLK) disable iff (SRST)
    FALL_IRQ == (st.fall_flag && st.ctrl[1]))
    else $error("fall request not gated");
  a_rise_gate: assert property (@(posedge CLK) disable iff (SRST)
    RISE_IRQ |-> st.ctrl[0])
    else $error("rise request without enable");
  a_reset_drop: assert property (@(posedge CLK) disable iff (SRST)
    (drop && !UNDERVOLT_RESET) |=> UNDERVOLT_RESET)
    else $error("drop did not assert reset");
  a_no_reset_off: assert property (@(posedge CLK) disable iff (SRST)
    (!UNDERVOLT_RESET && !drop) |=> !UNDERVOLT_RESET)
    else $error("reset without drop");
  a_hold_time: assert property (@(posedge CLK) disable iff (SRST)
    $fell(UNDERVOLT_RESET) |-> $past(st.hold_cnt) >= HOLD_CYCLES - 1)
    else $error("reset released early");
  a_standby: assert property (@(posedge CLK) disable iff (SRST)
    !sup_on |=> !st.fall_armed)
    else $error("armed in standby");
  a_fall_flag: assert property (@(posedge CLK) disable iff (SRST)
    (fall_evt && !UNDERVOLT_RESET) |=> st.fall_flag)
    else $error("fall flag not set");
  a_keep_ctrl: assert property (@(posedge CLK) disable iff (SRST)
    UNDERVOLT_RESET |=> (st.ctrl & `LVD_CTRL_KEEP_MASK) ==
                        ($past(st.ctrl) & `LVD_CTRL_KEEP_MASK))
    else $error("kept field lost");
  a_reset_fields: assert property (@(posedge CLK) disable iff (SRST)
    UNDERVOLT_RESET |=> (st.ctrl & ~`LVD_CTRL_KEEP_MASK) ==
                        (`LVD_CTRL_RESET & ~`LVD_CTRL_KEEP_MASK))
    else $error("unkept field not reset");
  a_sup_lands: assert property (@(posedge CLK) disable iff (SRST)
    (wr && PADDR == `LVD_CTRL_OFS && !UNDERVOLT_RESET) |=>
      SUPERVISOR_ON == $past(PWDATA[`LVD_SUP_EN_BIT]))
    else $error("supervisor enable not taken");
  a_ref_lands: assert property (@(posedge CLK) disable iff (SRST)
    (wr && PADDR == `LVD_CTRL_OFS && !UNDERVOLT_RESET) |=>
      REFERENCE_ON == $past(PWDATA[`LVD_REF_EN_BIT]))
    else $error("reference enable not taken");
  a_src_lands: assert property (@(posedge CLK) disable iff (SRST)
    (wr && PADDR == `LVD_CTRL_OFS && !UNDERVOLT_RESET) |=>
      COMPARE_INTERNAL == $past(PWDATA[`LVD_SRC_SEL_BIT]))
    else $error("compare source not taken");
  a_thr_lands: assert property (@(posedge CLK) disable iff (SRST)
    (wr && PADDR == `LVD_CTRL_OFS && !UNDERVOLT_RESET) |=>
      THRESHOLD_HIGH == $past(PWDATA[`LVD_THR_SEL_BIT]))
    else $error("threshold select not taken");
  a_flags_drop: assert property (@(posedge CLK) disable iff (SRST)
    UNDERVOLT_RESET |=> !st.fall_flag && !st.rise_flag)
    else $error("flags survived supervisor reset");
  a_clear_read: assert property (@(posedge CLK) disable iff (SRST)
    (st.fall_flag && !st.fall_read && !UNDERVOLT_RESET) |=> st.fall_flag)
    else $error("fall flag cleared without read");
  a_rise_flag: assert property (@(posedge CLK) disable iff (SRST)
    (rise_evt && !UNDERVOLT_RESET) |=> st.rise_flag)
    else $error("rise flag not set");
  a_hold_low: assert property (@(posedge CLK) disable iff (SRST)
    (UNDERVOLT_RESET && below_rst) |=> UNDERVOLT_RESET)
    else $error("reset released while supply low");
  a_stat_clear: assert property (@(posedge CLK) disable iff (SRST)
    (rd && PADDR == `LVD_IRQ_STAT_OFS && !fall_evt && !rise_evt) |=>
      (st.irq_stat & $past(st.prdata[1:0])) == 2'h0)
    else $error("reported status bit not cleared");
  c_flag_clear: cover property (@(posedge CLK)
    wr && PADDR == `LVD_STAT_OFS && st.fall_read);
  c_reset_seq: cover property (@(posedge CLK) $fell(UNDERVOLT_RESET));
  c_fall_irq: cover property (@(posedge CLK) $rose(FALL_IRQ));
  c_rise_irq: cover property (@(posedge CLK) $rose(RISE_IRQ));

endmodule
`default_nettype wire

// >>> verif/supply_monitor_bench.sv
// self-checking bench for the supply supervisor control block
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_bench;
  // ****************************************
  // signals and instance
  // ****************************************
  localparam int unsigned HOLD = 8;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        blw_rst, blw_fall, abv_rise, slv;
  logic        sup_on, ref_on, cmp_int, thr_hi, uv_rst, f_irq, r_irq, irq;
  int          err_count, n_compared, n;

  supply_monitor #(.HOLD_CYCLES(HOLD)) supply_monitor_inst (
    .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .BELOW_RESET_LVL(blw_rst),
    .BELOW_FALL_LVL(blw_fall), .ABOVE_RISE_LVL(abv_rise),
    .SUPERVISOR_ON(sup_on), .REFERENCE_ON(ref_on),
    .COMPARE_INTERNAL(cmp_int), .THRESHOLD_HIGH(thr_hi),
    .UNDERVOLT_RESET(uv_rst), .FALL_IRQ(f_irq), .RISE_IRQ(r_irq), .IRQ(irq));

  // free-running 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      wrap_up();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    apb(1'b0, 12'h000, 32'h0); check("ctrl reset", rd, 32'h0000_00f4);
    apb(1'b0, 12'h004, 32'h0); check("stat reset", rd, 32'h0000_00fc);
    check("analog on", {sup_on, ref_on, cmp_int, thr_hi}, 32'h0000_000e);
    apb(1'b1, 12'h000, 32'h0000_0008);
    apb(1'b0, 12'h000, 32'h0); check("ctrl fixed", rd, 32'h0000_0018);
    idle(1);
    check("analog off", {sup_on, ref_on, cmp_int, thr_hi}, 32'h1);
    apb(1'b0, 12'h010, 32'h0); check("unmapped err", slv, 32'h1);
    $display("test regs done");
  endtask

  task automatic t_events();
    apb(1'b1, 12'h000, 32'h0000_00e3); // low threshold with irqs
    blw_fall <= 1'b1;
    idle(5);
    apb(1'b0, 12'h004, 32'h0); check("fall flag", rd, 32'h0000_00fe);
    check("fall irq", {f_irq, r_irq}, 32'h2);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b0, 12'h004, 32'h0); check("fall clear", rd, 32'h0000_00fc);
    blw_fall <= 1'b0; abv_rise <= 1'b1;
    idle(5);
    apb(1'b1, 12'h004, 32'h0); // unread flag must survive
    apb(1'b0, 12'h004, 32'h0); check("rise flag", rd, 32'h0000_00fd);
    check("rise irq", {f_irq, r_irq}, 32'h1);
    check("irq masked", irq, 32'h0);
    apb(1'b1, 12'h00c, 32'h3); idle(1);
    check("irq on", irq, 32'h1);
    apb(1'b0, 12'h008, 32'h0); check("irq stat", rd, 32'h3);
    idle(1); check("irq cleared", irq, 32'h0);
    apb(1'b1, 12'h000, 32'h0000_00f0); idle(1);
    check("rise blocked", r_irq, 32'h0);
    abv_rise <= 1'b0;
    $display("test events done");
  endtask

  task automatic t_reset();
    apb(1'b1, 12'h000, 32'h0000_00e7);
    blw_rst <= 1'b1;
    for (n = 0; n < 10 && uv_rst !== 1'b1; n++) @(posedge clk);
    check("uv reset on", uv_rst, 32'h1);
    blw_rst <= 1'b0;
    for (n = 0; n < 100 && uv_rst === 1'b1; n++) @(posedge clk);
    check("hold length", (n >= HOLD && n <= HOLD + 4), 32'h1);
    apb(1'b0, 12'h000, 32'h0); check("ctrl kept", rd, 32'h0000_00f4);
    apb(1'b1, 12'h000, 32'h0000_00f0);
    blw_rst <= 1'b1;
    idle(6);
    check("uv reset off", uv_rst, 32'h0);
    blw_rst <= 1'b0;
    $display("test reset done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    err_count = 0; n_compared = 0;
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0;
    blw_rst = 1'b0; blw_fall = 1'b0; abv_rise = 1'b0;
    idle(6);
    srst <= 1'b0;
    t_regs();
    t_events();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
